/* File: hw/tca_pkg.sv */
// Constants, register map and state codes for the transfer controller.
// Assumes a 100 MHz core clock and an Avalon-MM register bus with byte addresses.
package tca_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] OFS_SWACT = 12'h000;    // Software activation register
  localparam logic [11:0] OFS_ENABLE = 12'h004;   // Activation enable register
  localparam logic [11:0] OFS_MSTOP = 12'h008;    // Module stop register
  localparam logic [11:0] OFS_SYSCTL = 12'h00C;   // System control register
  localparam logic [11:0] OFS_STATUS = 12'h010;   // Engine status
  localparam logic [11:0] OFS_STATES = 12'h014;   // Execution states of last activation
  localparam logic [3:0] DESC_PAGE = 4'h4;        // Descriptor RAM at 0x400..0x4FC
  localparam logic [2:0] VTAB_PAGE = 3'h4;        // Vector table at 0x800..0x9FC

  // Software activation register layout
  localparam int unsigned SWACT_FLAG_BIT = 7;     // Activate flag above the vector
  localparam int unsigned VEC_W = 7;              // Vector number width

  // Vector table origin seen by software, two bytes per vector
  localparam logic [15:0] VTAB_BASE = 16'h0400;

  // Mode register A fields
  localparam int unsigned SM_HI = 7;
  localparam int unsigned SM_LO = 6;
  localparam int unsigned DM_HI = 5;
  localparam int unsigned DM_LO = 4;
  localparam int unsigned XM_HI = 3;
  localparam int unsigned XM_LO = 2;
  localparam int unsigned BLOCK_SIDE_SELECT_BIT = 1; // 1: destination is the block area
  localparam int unsigned SIZE_SELECT_BIT = 0;    // 0: byte, 1: word
  // Mode register B fields
  localparam int unsigned CHAIN_BIT = 7;
  localparam int unsigned PER_TRANSFER_IRQ_FLAG_BIT = 6;

  // Address and transfer mode encodings
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  localparam logic [1:0] XM_NORMAL = 2'h0;
  localparam logic [1:0] XM_BLOCK = 2'h2;

  // Descriptor: word0 {mode A, source}, word1 {mode B, dest}, word2 {counter A, counter B}
  localparam logic [5:0] DESC_STRIDE = 6'h04;

  // Execution-state costs, all accesses on-chip with one state each
  localparam logic [15:0] COST_VEC = 16'h0001;    // One vector read
  localparam logic [15:0] COST_DESC = 16'h0006;   // Six descriptor read/write states
  localparam logic [15:0] COST_RD = 16'h0001;     // Per data read
  localparam logic [15:0] COST_WR = 16'h0001;     // Per data write
  localparam logic [15:0] COST_INT = 16'h0003;    // Internal operations

  // Activation sources
  localparam int unsigned NUM_SRC = 8;
  localparam logic [6:0] SRC_VEC_BASE = 7'h20;    // Source i uses vector base + i

  // Reset values
  localparam logic [7:0] RST_SWACT = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic RST_MSTOP = 1'b0;
  localparam logic RST_RAM_ENABLE = 1'b1;

  // Engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_VEC = 7'h02,
    ST_DESC = 7'h04,
    ST_RD = 7'h08,
    ST_CAP = 7'h10,
    ST_WRT = 7'h20,
    ST_WB = 7'h40
  } tca_state_t;

endpackage : tca_pkg

/* File: hw/tca_transfer_controller.sv */
// Transfer controller: activation, descriptor fetch, data move and end handling.
// Assumes same-clock requesters and a data memory answering a read one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tca_transfer_controller (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] act_req_i,
  output logic [7:0] cpu_irq_o,
  output logic [7:0] src_flag_clr_o,
  output logic sw_end_irq_o,
  output logic [23:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_word_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i
);

  // Storage for descriptors and vector entries
  logic [31:0] desc_mem [64];         // Descriptor RAM, word addressed
  logic [7:0] vtab_mem [128];         // Descriptor byte offset per vector

  // Bus side
  logic wait_q;                       // Waitrequest, high while idle
  logic [31:0] rdata_q;               // Registered read answer
  logic bus_go;                       // Access taken this cycle
  logic [31:0] be_mask;               // Byte lanes as bit mask
  logic [31:0] rd_mux;                // Read data before registering
  logic wr_swact, wr_enable, wr_mstop, wr_sysctl;

  // Software-visible control
  logic [7:0] swact_q;                // Flag and vector
  logic sw_pend_q;                    // Software start waiting
  logic swend_q;                      // Software end event held
  logic [7:0] enable_q;               // Per-source activation enables
  logic mstop_q;                      // Controller stop bit
  logic ram_enable_bit_q;             // RAM enable bit

  // Engine
  tca_pkg::tca_state_t state_q;
  logic [2:0] src_q;                  // Active hardware source
  logic sw_act_q;                     // Activation came from software
  localparam int unsigned VEC_W_L = tca_pkg::VEC_W;
  logic [VEC_W_L-1:0] vec_q;          // Vector number in use
  logic [15:0] tab_addr_q;            // Vector table address in use
  logic [5:0] ptr_q;                  // Descriptor word pointer
  logic [7:0] mode_reg_a_q, mode_reg_b_q;
  logic [23:0] source_addr_reg_q, dest_addr_reg_q, blk_base_q;
  logic [15:0] transfer_counter_a_q, transfer_counter_b_q;
  logic [8:0] blk_left_q;             // Data left in current block
  logic [15:0] acc_q, states_q;       // Running and final state counts
  logic [7:0] xfers_q;                // Descriptors in this activation
  logic [7:0] clr_q, irq_q;
  logic swirq_q, rd_q, wr_q, word_q;
  logic [23:0] maddr_q;
  logic [15:0] wdata_q;

  // Decode helpers
  logic busy, settle, is_block, is_chain, is_last, irq_due, blk_end;
  logic [7:0] pend;
  logic [2:0] pick;
  logic [23:0] step, source_addr_next, dest_addr_next;
  logic [5:0] vptr;

  // Address update per mode
  function automatic logic [23:0] adv(input logic [1:0] m, input logic [23:0] a, input logic [23:0] s);
    logic [23:0] r;
    r = a;
    case (m)
      tca_pkg::AM_INC: r = a + s;
      tca_pkg::AM_DEC: r = a - s;
      default: r = a;
    endcase
    return r;
  endfunction : adv

  assign bus_go = (avs_read_i | avs_write_i) & wait_q;
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_swact = bus_go & avs_write_i & (avs_address_i == tca_pkg::OFS_SWACT) & avs_byteenable_i[0];
  assign wr_enable = bus_go & avs_write_i & (avs_address_i == tca_pkg::OFS_ENABLE) & avs_byteenable_i[0];
  assign wr_mstop = bus_go & avs_write_i & (avs_address_i == tca_pkg::OFS_MSTOP) & avs_byteenable_i[0];
  assign wr_sysctl = bus_go & avs_write_i & (avs_address_i == tca_pkg::OFS_SYSCTL) & avs_byteenable_i[0];

  // Busy covers anything that could start or is running
  assign pend = act_req_i & enable_q;
  assign busy = (state_q != tca_pkg::ST_IDLE) | sw_pend_q | (|pend);
  // Give a peripheral one cycle to drop its request after a flag clear
  assign settle = |clr_q;
  assign is_block = (mode_reg_a_q[tca_pkg::XM_HI:tca_pkg::XM_LO] == tca_pkg::XM_BLOCK);
  assign is_chain = mode_reg_b_q[tca_pkg::CHAIN_BIT];
  assign is_last = is_block ? (transfer_counter_b_q == 16'h0000) : (transfer_counter_a_q == 16'h0000);
  assign irq_due = mode_reg_b_q[tca_pkg::PER_TRANSFER_IRQ_FLAG_BIT] | is_last;
  assign blk_end = !is_block | (blk_left_q == 9'h001);
  assign step = mode_reg_a_q[tca_pkg::SIZE_SELECT_BIT] ? 24'h000002 : 24'h000001;
  assign source_addr_next = adv(mode_reg_a_q[tca_pkg::SM_HI:tca_pkg::SM_LO], source_addr_reg_q, step);
  assign dest_addr_next = adv(mode_reg_a_q[tca_pkg::DM_HI:tca_pkg::DM_LO], dest_addr_reg_q, step);
  assign vptr = vtab_mem[vec_q][7:2];

  // Lowest-numbered enabled source wins
  always_comb begin
    pick = 3'h0;
    for (int i = tca_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 3'(i);
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_i[11:8] == tca_pkg::DESC_PAGE) begin
      rd_mux = desc_mem[avs_address_i[7:2]];
    end else if (avs_address_i[11:9] == tca_pkg::VTAB_PAGE) begin
      rd_mux = {24'h000000, vtab_mem[avs_address_i[8:2]]};
    end else begin
      case (avs_address_i)
        tca_pkg::OFS_SWACT: rd_mux = {24'h000000, swact_q};
        tca_pkg::OFS_ENABLE: rd_mux = {24'h000000, enable_q};
        tca_pkg::OFS_MSTOP: rd_mux = {31'h00000000, mstop_q};
        tca_pkg::OFS_SYSCTL: rd_mux = {31'h00000000, ram_enable_bit_q};
        tca_pkg::OFS_STATUS: rd_mux = {xfers_q, 5'h00, swend_q, sw_act_q, busy, tab_addr_q};
        tca_pkg::OFS_STATES: rd_mux = {16'h0000, states_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !bus_go;
      if (bus_go & avs_read_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Software activation register; a software write beats a hardware clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      swact_q <= tca_pkg::RST_SWACT;
      sw_pend_q <= 1'b0;
      swend_q <= 1'b0;
    end else begin
      if (wr_swact) begin
        swact_q <= avs_writedata_i[7:0];
        sw_pend_q <= avs_writedata_i[tca_pkg::SWACT_FLAG_BIT];
        if (!avs_writedata_i[tca_pkg::SWACT_FLAG_BIT]) begin
          swend_q <= 1'b0;
        end
      end else if (state_q == tca_pkg::ST_IDLE && !mstop_q && ram_enable_bit_q && !settle && pend == 8'h00) begin
        sw_pend_q <= 1'b0;
      end
      if (state_q == tca_pkg::ST_WB && sw_act_q && !is_chain) begin
        if (irq_due) begin
          swend_q <= 1'b1;
        end else if (!wr_swact) begin
          swact_q[tca_pkg::SWACT_FLAG_BIT] <= 1'b0;
        end
      end
    end
  end

  // Activation enables; a write from software wins over the hardware clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_q <= tca_pkg::RST_ENABLE;
    end else if (wr_enable) begin
      enable_q <= avs_writedata_i[7:0];
    end else if (state_q == tca_pkg::ST_WB && !sw_act_q && !is_chain && irq_due) begin
      enable_q[src_q] <= 1'b0;
    end
  end

  // Module stop and RAM enable
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mstop_q <= tca_pkg::RST_MSTOP;
      ram_enable_bit_q <= tca_pkg::RST_RAM_ENABLE;
    end else begin
      if (wr_mstop && !(avs_writedata_i[0] && busy)) begin
        mstop_q <= avs_writedata_i[0];
      end
      if (wr_sysctl) begin
        ram_enable_bit_q <= avs_writedata_i[0];
      end
    end
  end

  // Descriptor RAM and vector table: bus writes and descriptor write-back
  always_ff @(posedge core_clk_i) begin
    if (bus_go && avs_write_i && avs_address_i[11:8] == tca_pkg::DESC_PAGE) begin
      desc_mem[avs_address_i[7:2]] <= (desc_mem[avs_address_i[7:2]] & ~be_mask) | (avs_writedata_i & be_mask);
    end else if (state_q == tca_pkg::ST_WB) begin
      desc_mem[ptr_q] <= {mode_reg_a_q, source_addr_reg_q};
      desc_mem[6'(ptr_q + 6'h01)] <= {mode_reg_b_q, dest_addr_reg_q};
      desc_mem[6'(ptr_q + 6'h02)] <= {transfer_counter_a_q, transfer_counter_b_q};
    end
    if (bus_go && avs_write_i && avs_address_i[11:9] == tca_pkg::VTAB_PAGE && avs_byteenable_i[0]) begin
      vtab_mem[avs_address_i[8:2]] <= avs_writedata_i[7:0];
    end
  end

  // Transfer engine
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= tca_pkg::ST_IDLE;
      src_q <= 3'h0;
      sw_act_q <= 1'b0;
      vec_q <= '0;
      tab_addr_q <= 16'h0000;
      ptr_q <= 6'h00;
      mode_reg_a_q <= 8'h00;
      mode_reg_b_q <= 8'h00;
      source_addr_reg_q <= 24'h000000;
      dest_addr_reg_q <= 24'h000000;
      blk_base_q <= 24'h000000;
      transfer_counter_a_q <= 16'h0000;
      transfer_counter_b_q <= 16'h0000;
      blk_left_q <= 9'h000;
      acc_q <= 16'h0000;
      states_q <= 16'h0000;
      xfers_q <= 8'h00;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      word_q <= 1'b0;
      maddr_q <= 24'h000000;
      wdata_q <= 16'h0000;
    end else begin
      unique case (state_q)
        tca_pkg::ST_IDLE: begin
          // Descriptors live in RAM, so nothing starts while it is off
          if (!mstop_q && ram_enable_bit_q && !settle && (pend != 8'h00 || sw_pend_q)) begin
            sw_act_q <= (pend == 8'h00);
            src_q <= pick;
            vec_q <= (pend != 8'h00) ? 7'(tca_pkg::SRC_VEC_BASE + {4'h0, pick}) : swact_q[6:0];
            acc_q <= 16'h0000;
            xfers_q <= 8'h00;
            state_q <= tca_pkg::ST_VEC;
          end
        end
        tca_pkg::ST_VEC: begin
          tab_addr_q <= tca_pkg::VTAB_BASE + {8'h00, vec_q, 1'b0};
          ptr_q <= vptr;
          acc_q <= acc_q + tca_pkg::COST_VEC;
          state_q <= tca_pkg::ST_DESC;
        end
        tca_pkg::ST_DESC: begin
          {mode_reg_a_q, source_addr_reg_q} <= desc_mem[ptr_q];
          {mode_reg_b_q, dest_addr_reg_q} <= desc_mem[6'(ptr_q + 6'h01)];
          {transfer_counter_a_q, transfer_counter_b_q} <= desc_mem[6'(ptr_q + 6'h02)];
          // Block size 0 means 256
          blk_left_q <= {desc_mem[6'(ptr_q + 6'h02)][31:24] == 8'h00, desc_mem[6'(ptr_q + 6'h02)][31:24]};
          blk_base_q <= desc_mem[ptr_q][24 + tca_pkg::BLOCK_SIDE_SELECT_BIT] ? desc_mem[6'(ptr_q + 6'h01)][23:0]
                                                                            : desc_mem[ptr_q][23:0];
          xfers_q <= xfers_q + 8'h01;
          acc_q <= acc_q + tca_pkg::COST_DESC;
          word_q <= desc_mem[ptr_q][24 + tca_pkg::SIZE_SELECT_BIT];
          maddr_q <= desc_mem[ptr_q][23:0];
          rd_q <= 1'b1;
          state_q <= tca_pkg::ST_RD;
        end
        tca_pkg::ST_RD: begin
          rd_q <= 1'b0;
          state_q <= tca_pkg::ST_CAP;
        end
        tca_pkg::ST_CAP: begin
          wdata_q <= mem_rdata_i;
          maddr_q <= dest_addr_reg_q;
          wr_q <= 1'b1;
          acc_q <= acc_q + tca_pkg::COST_RD;
          state_q <= tca_pkg::ST_WRT;
        end
        tca_pkg::ST_WRT: begin
          wr_q <= 1'b0;
          acc_q <= acc_q + tca_pkg::COST_WR;
          source_addr_reg_q <= source_addr_next;
          dest_addr_reg_q <= dest_addr_next;
          blk_left_q <= blk_left_q - 9'h001;
          if (!blk_end) begin
            transfer_counter_a_q[7:0] <= transfer_counter_a_q[7:0] - 8'h01;
            maddr_q <= source_addr_next;
            rd_q <= 1'b1;
            state_q <= tca_pkg::ST_RD;
          end else begin
            if (is_block) begin
              // Block done: reload size count, rewind the block area
              transfer_counter_a_q[7:0] <= transfer_counter_a_q[15:8];
              transfer_counter_b_q <= transfer_counter_b_q - 16'h0001;
              if (mode_reg_a_q[tca_pkg::BLOCK_SIDE_SELECT_BIT]) begin
                dest_addr_reg_q <= blk_base_q;
              end else begin
                source_addr_reg_q <= blk_base_q;
              end
            end else begin
              transfer_counter_a_q <= transfer_counter_a_q - 16'h0001;
            end
            state_q <= tca_pkg::ST_WB;
          end
        end
        tca_pkg::ST_WB: begin
          if (is_chain) begin
            ptr_q <= 6'(ptr_q + tca_pkg::DESC_STRIDE);
            state_q <= tca_pkg::ST_DESC;
          end else begin
            states_q <= acc_q + tca_pkg::COST_INT;
            state_q <= tca_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Side-band outputs: flag clears, forwarded interrupts, software end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_q <= 8'h00;
      irq_q <= 8'h00;
      swirq_q <= 1'b0;
    end else begin
      clr_q <= 8'h00;
      if (state_q == tca_pkg::ST_WB && !sw_act_q && !is_chain && !irq_due) begin
        clr_q[src_q] <= 1'b1;
      end
      // A disabled source goes to the CPU, which applies mask and priority
      irq_q <= act_req_i & ~enable_q;
      swirq_q <= swend_q & !sw_pend_q & !(sw_act_q & (state_q != tca_pkg::ST_IDLE));
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign cpu_irq_o = irq_q;
  assign src_flag_clr_o = clr_q;
  assign sw_end_irq_o = swirq_q;
  assign mem_addr_o = maddr_q;
  assign mem_rd_o = rd_q;
  assign mem_wr_o = wr_q;
  assign mem_word_o = word_q;
  assign mem_wdata_o = wdata_q;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wb_final;
    state_q == tca_pkg::ST_WB && !is_chain;
  endsequence
  sequence s_sw_start;
    wr_swact && avs_writedata_i[tca_pkg::SWACT_FLAG_BIT];
  endsequence

  AST_SW_START: assert property (s_sw_start |=> sw_pend_q || state_q == tca_pkg::ST_VEC)
    else $error("software start not taken");
  AST_TAB_ADDR: assert property (state_q == tca_pkg::ST_DESC |-> tab_addr_q == 16'h0400 + {8'h00, vec_q, 1'b0})
    else $error("vector table address wrong");
  AST_SW_CLEAR: assert property (s_wb_final ##0 (sw_act_q && !irq_due && !wr_swact) |=> !swact_q[7] && !swend_q)
    else $error("software activate bit not cleared");
  AST_SW_END: assert property (s_wb_final ##0 (sw_act_q && irq_due) |=> swend_q ##1 sw_end_irq_o || sw_pend_q)
    else $error("software end interrupt missing");
  AST_EN_CLEAR: assert property (s_wb_final ##0 (!sw_act_q && irq_due && !wr_enable) |=> !enable_q[src_q])
    else $error("activation enable not cleared");
  AST_FLAG_CLR: assert property (s_wb_final ##0 (!sw_act_q && !irq_due) |=> src_flag_clr_o[src_q] ##1 !src_flag_clr_o[src_q])
    else $error("receive flag clear pulse wrong");
  AST_NO_SWIRQ: assert property ((sw_pend_q || (sw_act_q && state_q != tca_pkg::ST_IDLE)) |=> !sw_end_irq_o)
    else $error("software end interrupt while pending");
  AST_STOP_IDLE: assert property ($rose(mstop_q) |-> $past(state_q) == tca_pkg::ST_IDLE)
    else $error("module stop accepted while busy");
  AST_NORMAL_STEP: assert property ((state_q == tca_pkg::ST_WRT && !is_block && mode_reg_a_q == 8'h20)
    |=> dest_addr_reg_q == $past(dest_addr_reg_q) + 24'h000001 && source_addr_reg_q == $past(source_addr_reg_q)
    && transfer_counter_a_q == $past(transfer_counter_a_q) - 16'h0001)
    else $error("normal mode step wrong");
  AST_CHAIN_QUIET: assert property ((state_q == tca_pkg::ST_WB && is_chain) |=> state_q == tca_pkg::ST_DESC
    && src_flag_clr_o == 8'h00)
    else $error("chain step raised a source effect");
  AST_STATES: assert property (s_wb_final |=> states_q == $past(acc_q) + 16'h0003)
    else $error("execution state count wrong");

endmodule : tca_transfer_controller
`default_nettype wire

/* File: verif/tca_far_model.sv */
// Far side: data memory and peripheral request lines.
// Assumes byte transfers and the controller clock.
`timescale 1ns/1ps
`default_nettype none
module tca_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [23:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [7:0] clr_i,
  input wire logic [7:0] set_i,
  input wire logic [7:0] drop_i,
  output logic [15:0] rdata_o,
  output logic [7:0] req_o
);
  logic [7:0] mem_q [0:1023]; // Byte store, preloaded by the bench
  // Data only after a read, else a toggling pattern
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) rdata_o <= 16'hA5A5;
    else rdata_o <= rd_i ? {8'h00, mem_q[addr_i[9:0]]} : ~rdata_o;
  end
  // Writes land in the store
  always @(posedge clk_i) begin
    if (wr_i) mem_q[addr_i[9:0]] <= wdata_i[7:0];
  end
  // Request holds until cleared by the controller or dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) req_o <= 8'h00;
    else req_o <= (req_o | set_i) & ~clr_i & ~drop_i;
  end
endmodule : tca_far_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench: software and interrupt activation of the controller.
// Assumes tca_far_model as memory and requester.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] avs_address_i = 12'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, d;
  logic avs_waitrequest_o, sw_end_irq_o, mem_rd_o, mem_wr_o, mem_word_o;
  logic [7:0] act_req_i, cpu_irq_o, src_flag_clr_o, r0, r1;
  logic [7:0] req_set = 8'h00;
  logic [7:0] req_drop = 8'h00;
  logic [23:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic [31:0] exp_q [$]; // Expected {address, data} of writes
  int errors = 0;
  int n_compared = 0;
  int n_clr = 0;
  int n_rd = 0; // Data reads seen on the far side
  always #5 core_clk_i = ~core_clk_i;
  tca_transfer_controller tca_transfer_controller_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .act_req_i(act_req_i), .cpu_irq_o(cpu_irq_o),
    .src_flag_clr_o(src_flag_clr_o), .sw_end_irq_o(sw_end_irq_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_word_o(mem_word_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i));
  tca_far_model tca_far_model_inst (.clk_i(core_clk_i), .rst_i(rst_i), .addr_i(mem_addr_o),
    .rd_i(mem_rd_o), .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .clr_i(src_flag_clr_o),
    .set_i(req_set), .drop_i(req_drop), .rdata_o(mem_rdata_i), .req_o(act_req_i));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n = 0;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) errors++;
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, d & m);
  endtask : rdc
  // Polls busy; bounded at 50 polls so a stuck engine counts an error and the run goes on
  task automatic idle_wait();
    int n = 0;
    repeat (3) @(posedge core_clk_i);
    do begin
      bus(1'b0, tca_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (d[16] !== 1'b0 && n < 50);
    if (n >= 50) errors++;
  endtask : idle_wait
  task automatic desc(input logic [11:0] a, input logic [31:0] w0, w1, w2);
    bus(1'b1, a, w0);
    bus(1'b1, a + 12'h004, w1);
    bus(1'b1, a + 12'h008, w2);
  endtask : desc
  task automatic kick();
    req_set <= 8'h01;
    @(posedge core_clk_i);
    req_set <= 8'h00;
    idle_wait();
  endtask : kick
  // Each data write takes the oldest expected note
  always @(posedge core_clk_i) begin
    if (src_flag_clr_o[0] === 1'b1) n_clr++;
    if (mem_rd_o === 1'b1) n_rd++;
    if (mem_rd_o === 1'b1) chk("read size", 32'h0, {31'h0, mem_word_o});
    if (mem_wr_o === 1'b1) chk("data write", exp_q.pop_front(), {mem_addr_o[15:0], mem_wdata_o});
  end
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h6B81));
    r0 = 8'($urandom());
    r1 = 8'($urandom());
    tca_far_model_inst.mem_q[256] = r0;
    tca_far_model_inst.mem_q[272] = r1;
    tca_far_model_inst.mem_q[257] = ~r0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rdc(12'hFFC, 32'hFFFFFFFF, 32'h0);
    rdc(tca_pkg::OFS_SYSCTL, 32'h1, 32'h1);
    // Fixed source, incrementing byte destination, two transfers
    desc(12'h400, 32'h20000100, 32'h00000200, 32'h00020000);
    bus(1'b1, 12'h980, 32'h0);
    exp_q.push_back({16'h0200, 8'h00, r0});
    bus(1'b1, tca_pkg::OFS_SWACT, 32'hE0);
    bus(1'b1, tca_pkg::OFS_MSTOP, 32'h1);
    chk("sw end irq", 32'h0, {31'h0, sw_end_irq_o});
    rdc(tca_pkg::OFS_SWACT, 32'h7F, 32'h60);
    idle_wait();
    rdc(tca_pkg::OFS_MSTOP, 32'h1, 32'h0);
    // Stop taken while idle, then released again
    bus(1'b1, tca_pkg::OFS_MSTOP, 32'h1);
    rdc(tca_pkg::OFS_MSTOP, 32'h1, 32'h1);
    bus(1'b1, tca_pkg::OFS_MSTOP, 32'h0);
    rdc(tca_pkg::OFS_SWACT, 32'hFF, 32'h60);
    rdc(tca_pkg::OFS_STATES, 32'hFFFF, 32'h0000000C);
    rdc(tca_pkg::OFS_STATUS, 32'hFF00FFFF, 32'h010004C0);
    exp_q.push_back({16'h0201, 8'h00, r0});
    bus(1'b1, tca_pkg::OFS_SWACT, 32'hE0);
    idle_wait();
    rdc(tca_pkg::OFS_SWACT, 32'hFF, 32'hE0);
    chk("sw end irq", 32'h1, {31'h0, sw_end_irq_o});
    bus(1'b1, tca_pkg::OFS_SWACT, 32'h0);
    // Chained pair at word 16: one normal byte, then one block of two bytes
    desc(12'h440, 32'h20000110, 32'h80000380, 32'h00010000);
    desc(12'h450, 32'hA8000100, 32'h00000390, 32'h02020001);
    bus(1'b1, 12'h984, 32'h40);
    exp_q.push_back({16'h0380, 8'h00, r1});
    exp_q.push_back({16'h0390, 8'h00, r0});
    exp_q.push_back({16'h0391, 8'h00, ~r0});
    bus(1'b1, tca_pkg::OFS_SWACT, 32'hE1);
    chk("sw end irq", 32'h0, {31'h0, sw_end_irq_o});
    idle_wait();
    rdc(tca_pkg::OFS_STATES, 32'hFFFF, 32'h00000016);
    rdc(tca_pkg::OFS_STATUS, 32'hFF00FFFF, 32'h020004C2);
    rdc(tca_pkg::OFS_SWACT, 32'hFF, 32'hE1);
    bus(1'b1, tca_pkg::OFS_SWACT, 32'h0);
    // Source 0 through vector 0x20, descriptor at word 8
    desc(12'h420, 32'h20000110, 32'h00000300, 32'h00020000);
    bus(1'b1, 12'h880, 32'h20);
    bus(1'b1, tca_pkg::OFS_ENABLE, 32'h1);
    exp_q.push_back({16'h0300, 8'h00, r1});
    kick();
    chk("flag clears", 32'h1, n_clr);
    rdc(tca_pkg::OFS_ENABLE, 32'hFF, 32'h1);
    chk("cpu irq", 32'h0, {24'h0, cpu_irq_o});
    exp_q.push_back({16'h0301, 8'h00, r1});
    kick();
    rdc(tca_pkg::OFS_ENABLE, 32'hFF, 32'h0);
    chk("flag clears", 32'h1, n_clr);
    chk("cpu irq", 32'h1, {24'h0, cpu_irq_o});
    req_drop <= 8'h01;
    repeat (3) @(posedge core_clk_i);
    chk("cpu irq", 32'h0, {24'h0, cpu_irq_o});
    chk("writes left", 32'h0, exp_q.size());
    chk("data reads", 32'h7, n_rd);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
